/* File: atx_tx.sv */
// multichannel i2s/lj transmitter with sample fifo and clock auto-detect
`timescale 1ns/10ps
`default_nettype none
`include "atx_params.svh"

module atx_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic push;
    logic pop;

    assign in_ready = (count != (AW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem[rd_ptr];

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
            if (push && !pop) begin
                count <= count + 1'b1;
            end else if (pop && !push) begin
                count <= count - 1'b1;
            end
        end
    end

    AST_FIFO_COUNT: assert property (@(posedge clk) disable iff (!rst_n)
        (push && !pop) |=> (count == $past(count) + 1'b1))
        else $error("fifo count did not follow a push");
endmodule

module atx_tx
    import atx_pkg::*;
#(
    parameter int BCLK_HALF_DIV = 6,
    parameter int FIFO_DEPTH = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire atx_cfg_s cfg,
    input wire logic [3:0] ch_en,
    input wire logic [3:0][5:0] ch_slot,
    input wire logic [10:0] master_half_bits,
    input wire logic frame_resync,
    input wire logic smp_valid,
    output logic smp_ready,
    input wire logic [31:0] smp_data,
    input wire logic bit_clk_pin_in,
    output logic bit_clk_pin_out,
    output logic bit_clk_pin_oe_n,
    input wire logic frame_sync_pin_in,
    output logic frame_sync_pin_out,
    output logic frame_sync_pin_oe_n,
    output logic sdout,
    output logic sdout_oe_n,
    output logic sdout_keep,
    output logic general_pin_one_out,
    output logic general_pin_one_oe_n,
    input wire logic general_input_pin,
    output atx_status_s clock_detect_status
);
    localparam int DW = $clog2(BCLK_HALF_DIV + 1);

    function automatic logic [5:0] word_len(input logic [1:0] code);
        case (code)
            2'h0: word_len = 6'h10;
            2'h1: word_len = 6'h14;
            2'h2: word_len = 6'h18;
            default: word_len = 6'h20;
        endcase
    endfunction

    function automatic logic [3:0] ratio_idx(input logic [11:0] r);
        case (r)
            12'h010: ratio_idx = 4'h1;
            12'h018: ratio_idx = 4'h2;
            12'h020: ratio_idx = 4'h3;
            12'h030: ratio_idx = 4'h4;
            12'h040: ratio_idx = 4'h5;
            12'h060: ratio_idx = 4'h6;
            12'h080: ratio_idx = 4'h7;
            12'h0c0: ratio_idx = 4'h8;
            12'h100: ratio_idx = 4'h9;
            12'h180: ratio_idx = 4'ha;
            12'h200: ratio_idx = 4'hb;
            12'h400: ratio_idx = 4'hc;
            12'h800: ratio_idx = 4'hd;
            default: ratio_idx = 4'h0;
        endcase
    endfunction

    logic rst_m;
    logic rst_q_n;
    logic [2:0] p1, p2, p3, pin_st;
    logic [DW-1:0] div_cnt;
    logic bclk_m, fs_m, force_left, m_fall;
    logic [10:0] half_cnt;
    logic is_i2s, is_lj, fmt_ok;
    logic bclk_sel, fs_sel, bclk_d, rise, fall;
    logic right, new_right, pstart, fstart, evt, go, emit;
    logic [5:0] dly, d0, bitc, slotc, nb, ns, wl;
    logic [11:0] pbits, need;
    logic [1:0] lane_own, lane_bit;
    logic mute;
    logic [31:0] cur [4];
    logic [31:0] nxt [4];
    atx_load_e ld_st;
    logic [1:0] ld_idx;
    logic ld_pop, fifo_valid;
    logic [31:0] fifo_data;
    logic [11:0] rcnt;
    logic [15:0] ccnt;
    logic next_err;

    // async assert, two-flop release
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_m <= 1'b0;
            rst_q_n <= 1'b0;
        end else begin
            rst_m <= 1'b1;
            rst_q_n <= rst_m;
        end
    end

    // pin inputs: a level counts once the second and third stage agree
    always_ff @(posedge clk or negedge rst_q_n) begin
        if (!rst_q_n) begin
            p1 <= '0;
            p2 <= '0;
            p3 <= '0;
            pin_st <= '0;
        end else begin
            p1 <= {general_input_pin, frame_sync_pin_in, bit_clk_pin_in};
            p2 <= p1;
            p3 <= p2;
            pin_st <= (p2 & ~(p2 ^ p3)) | (pin_st & (p2 ^ p3));
        end
    end

    assign is_i2s = (cfg.serial_format_select == `ATX_FMT_I2S);
    assign is_lj = (cfg.serial_format_select == `ATX_FMT_LJ);
    assign fmt_ok = is_i2s || is_lj;
    assign wl = word_len(cfg.sample_word_length);

    // master clock generation from the system clock
    assign m_fall = bclk_m && !frame_resync && (div_cnt == DW'(BCLK_HALF_DIV - 1));

    always_ff @(posedge clk or negedge rst_q_n) begin
        if (!rst_q_n) begin
            div_cnt <= '0;
            bclk_m <= 1'b0;
        end else if (frame_resync) begin
            div_cnt <= '0;
            bclk_m <= 1'b1;
        end else if (div_cnt == DW'(BCLK_HALF_DIV - 1)) begin
            div_cnt <= '0;
            bclk_m <= ~bclk_m;
        end else begin
            div_cnt <= div_cnt + 1'b1;
        end
    end

    // frame sync moves only together with a bit-clock fall
    always_ff @(posedge clk or negedge rst_q_n) begin
        if (!rst_q_n) begin
            fs_m <= 1'b0;
            half_cnt <= '0;
            force_left <= 1'b1;
        end else if (frame_resync) begin
            force_left <= 1'b1;
        end else if (m_fall) begin
            if (force_left || half_cnt == master_half_bits - 11'h1) begin
                fs_m <= force_left ? is_lj : ~fs_m;
                half_cnt <= '0;
                force_left <= 1'b0;
            end else begin
                half_cnt <= half_cnt + 11'h1;
            end
        end
    end

    assign bit_clk_pin_out = bclk_m ^ cfg.bit_clock_invert;
    assign bit_clk_pin_oe_n = !cfg.master_en;
    assign frame_sync_pin_out = fs_m;
    assign frame_sync_pin_oe_n = !cfg.master_en;

    assign bclk_sel = cfg.master_en ? bclk_m : (pin_st[0] ^ cfg.bit_clock_invert);
    assign fs_sel = cfg.master_en ? fs_m : pin_st[1];
    assign rise = bclk_sel && !bclk_d;
    assign fall = !bclk_sel && bclk_d;
    // i2s: low is left; lj: high is left
    assign new_right = is_lj ? !fs_sel : fs_sel;
    assign pstart = fmt_ok && (new_right != right);
    assign fstart = pstart && !new_right;
    assign evt = pstart || fall;

    // lj msb goes out at the phase edge itself, i2s one fall later
    always_comb begin
        d0 = pstart ? (6'(cfg.slot_offset) + 6'(is_i2s) + 6'(cfg.late_latch)) : dly;
        go = fmt_ok && evt && (d0 == 6'h0);
        nb = pstart ? 6'h0 : bitc;
        ns = pstart ? 6'h0 : slotc;
    end

    always_ff @(posedge clk or negedge rst_q_n) begin
        if (!rst_q_n) begin
            bclk_d <= 1'b0;
            right <= 1'b0;
            dly <= '0;
            bitc <= '0;
            slotc <= '0;
            emit <= 1'b0;
        end else begin
            bclk_d <= bclk_sel;
            right <= new_right;
            emit <= go;
            if (evt) begin
                dly <= (d0 != 6'h0) ? d0 - 6'h1 : 6'h0;
            end
            if (go) begin
                bitc <= (nb == wl - 6'h1) ? 6'h0 : nb + 6'h1;
                slotc <= (nb == wl - 6'h1 && !ns[5]) ? ns + 6'h1 : ns;
            end else if (pstart) begin
                bitc <= '0;
                slotc <= '0;
            end
        end
    end

    // slot match and lane steering
    always_comb begin
        lane_own = '0;
        lane_bit = '0;
        for (int c = 0; c < 4; c++) begin
            if (ch_en[c] && !ns[5] && ch_slot[c] == {new_right, ns[4:0]}) begin
                lane_own[c >= 2 && cfg.second_lane_en] = 1'b1;
                lane_bit[c >= 2 && cfg.second_lane_en] = !mute &&
                    (fstart ? nxt[c][5'h1f - nb[4:0]] : cur[c][5'h1f - nb[4:0]]);
            end
        end
    end

    always_ff @(posedge clk or negedge rst_q_n) begin
        if (!rst_q_n) begin
            sdout <= 1'b0;
            sdout_oe_n <= 1'b1;
            sdout_keep <= 1'b0;
        end else if (evt) begin
            if (go && lane_own[0]) begin
                sdout <= lane_bit[0];
                sdout_oe_n <= 1'b0;
                sdout_keep <= 1'b0;
            end else if (cfg.daisy_en) begin
                sdout <= pin_st[2];
                sdout_oe_n <= 1'b0;
                sdout_keep <= 1'b0;
            end else if (cfg.tristate_en) begin
                sdout_oe_n <= 1'b1;
                sdout_keep <= cfg.bus_hold_en;
                if (!cfg.bus_hold_en) begin
                    sdout <= 1'b0;
                end
            end else begin
                sdout <= 1'b0;
                sdout_oe_n <= 1'b0;
                sdout_keep <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_q_n) begin
        if (!rst_q_n) begin
            general_pin_one_out <= 1'b0;
            general_pin_one_oe_n <= 1'b1;
        end else if (!cfg.second_lane_en) begin
            general_pin_one_out <= 1'b0;
            general_pin_one_oe_n <= 1'b1;
        end else if (evt) begin
            general_pin_one_out <= go && lane_own[1] && lane_bit[1];
            general_pin_one_oe_n <= !(go && lane_own[1]) && cfg.tristate_en;
        end
    end

    // next-frame words fill while the current frame is on the wire
    assign ld_pop = (ld_st == LD_RUN) && ch_en[ld_idx] && fifo_valid;

    always_ff @(posedge clk or negedge rst_q_n) begin
        if (!rst_q_n) begin
            ld_st <= LD_IDLE;
            ld_idx <= '0;
            for (int c = 0; c < 4; c++) begin
                cur[c] <= '0;
                nxt[c] <= '0;
            end
        end else begin
            if (fstart) begin
                for (int c = 0; c < 4; c++) begin
                    cur[c] <= nxt[c];
                end
            end
            case (ld_st)
                LD_IDLE: begin
                    if (fstart) begin
                        ld_st <= LD_RUN;
                        ld_idx <= '0;
                    end
                end
                LD_RUN: begin
                    if (ld_pop || !ch_en[ld_idx]) begin
                        if (ld_pop) begin
                            nxt[ld_idx] <= fifo_data;
                        end
                        ld_idx <= ld_idx + 2'h1;
                        if (ld_idx == 2'h3) begin
                            ld_st <= LD_IDLE;
                        end
                    end
                end
                default: ld_st <= LD_IDLE;
            endcase
        end
    end

    atx_fifo #(
        .WIDTH(32),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .rst_n(rst_q_n),
        .in_valid(smp_valid),
        .in_ready(smp_ready),
        .in_data(smp_data),
        .out_valid(fifo_valid),
        .out_ready(ld_pop),
        .out_data(fifo_data)
    );

    // per-phase length check against active slots
    always_comb begin
        need = '0;
        for (int c = 0; c < 4; c++) begin
            if (ch_en[c] && ch_slot[c][`ATX_SLOT_RIGHT_BIT] == right) begin
                need = need + 12'(wl);
            end
        end
    end

    // clock detection per frame; clk_err only under auto config, phase_err always
    always_comb begin
        next_err = cfg.auto_clk_en && (ratio_idx(rcnt) == 4'h0 ||
            32'(ccnt) < 32'(`ATX_FRAME_CYC_MIN) || 32'(ccnt) > 32'(`ATX_FRAME_CYC_MAX) ||
            32'(ccnt) * 32'(`ATX_BCLK_MAX_KHZ) < 32'(rcnt) * 32'(`ATX_CLK_KHZ) ||
            32'(ccnt) * 32'(`ATX_BCLK_MIN_KHZ) > 32'(rcnt) * 32'(`ATX_CLK_KHZ));
    end

    assign mute = clock_detect_status.clk_err;

    always_ff @(posedge clk or negedge rst_q_n) begin
        if (!rst_q_n) begin
            pbits <= '0;
            rcnt <= '0;
            ccnt <= '0;
            clock_detect_status <= '0;
        end else begin
            if (pstart) begin
                pbits <= {11'h0, rise};
                clock_detect_status.phase_err <= (pbits < need);
            end else if (rise && pbits != 12'hfff) begin
                pbits <= pbits + 12'h1;
            end
            if (fstart) begin
                clock_detect_status.ratio_idx <= ratio_idx(rcnt);
                clock_detect_status.frame_cycles <= ccnt;
                clock_detect_status.clk_err <= next_err;
                rcnt <= {11'h0, rise};
                ccnt <= 16'h1;
            end else begin
                if (rise && rcnt != 12'hfff) begin
                    rcnt <= rcnt + 12'h1;
                end
                if (ccnt != 16'hffff) begin
                    ccnt <= ccnt + 16'h1;
                end else begin
                    // frame sync has stopped
                    clock_detect_status.clk_err <= cfg.auto_clk_en;
                end
            end
        end
    end

    AST_LJ_MSB_AT_EDGE: assert property (@(posedge clk) disable iff (!rst_q_n)
        (is_lj && pstart && cfg.slot_offset == 5'h0 && !cfg.late_latch) |=> emit)
        else $error("lj msb not launched at frame-sync edge");
    AST_I2S_MSB_DELAYED: assert property (@(posedge clk) disable iff (!rst_q_n)
        (is_i2s && pstart) |=> !emit)
        else $error("i2s msb launched without the one-bit delay");
    AST_EMIT_ON_FALL: assert property (@(posedge clk) disable iff (!rst_q_n)
        emit |-> $past(fall || pstart))
        else $error("data bit changed off a bit-clock fall");
    AST_FS_ON_FALL: assert property (@(posedge clk) disable iff (!rst_q_n)
        (cfg.master_en && $changed(frame_sync_pin_out)) |-> $fell(bclk_m))
        else $error("frame sync moved off a bit-clock fall");
    AST_OFFSET_ONE: assert property (@(posedge clk) disable iff (!rst_q_n)
        (is_lj && pstart && cfg.slot_offset == 5'h1 && !cfg.late_latch) |=> !emit)
        else $error("offset of one did not delay the slot start");
    AST_MUTE: assert property (@(posedge clk) disable iff (!rst_q_n)
        (go && lane_own[0] && mute) |=> (!sdout && !sdout_oe_n))
        else $error("owned slot not muted under clock error");
    AST_TRISTATE: assert property (@(posedge clk) disable iff (!rst_q_n)
        (evt && !(go && lane_own[0]) && !cfg.daisy_en && cfg.tristate_en) |=> sdout_oe_n)
        else $error("data driven in a slot not owned");
    AST_HOLD: assert property (@(posedge clk) disable iff (!rst_q_n)
        (evt && !(go && lane_own[0]) && !cfg.daisy_en && cfg.tristate_en && cfg.bus_hold_en)
        |=> (sdout_keep && $stable(sdout)))
        else $error("bus holder lost the last level");
    AST_BAD_RATIO: assert property (@(posedge clk) disable iff (!rst_q_n)
        (fstart && cfg.auto_clk_en && ratio_idx(rcnt) == 4'h0) |=> clock_detect_status.clk_err)
        else $error("unsupported ratio not flagged");
endmodule
`default_nettype wire

/* File: atx_params.svh */
// constants of the multichannel i2s/lj transmitter
`ifndef ATX_PARAMS_SVH
`define ATX_PARAMS_SVH
`define ATX_FMT_I2S 2'h1
`define ATX_FMT_LJ 2'h2
`define ATX_WLEN_RST 2'h3
`define ATX_CLK_KHZ 250000
`define ATX_FS_MIN_KHZ 8
`define ATX_FS_MAX_KHZ 768
`define ATX_BCLK_MIN_KHZ 256
`define ATX_BCLK_MAX_KHZ 24576
`define ATX_FRAME_CYC_MAX (`ATX_CLK_KHZ / `ATX_FS_MIN_KHZ)
`define ATX_FRAME_CYC_MIN ((`ATX_CLK_KHZ + `ATX_FS_MAX_KHZ - 1) / `ATX_FS_MAX_KHZ)
`define ATX_SLOT_RIGHT_BIT 5
`endif

/* File: atx_pkg.sv */
// types of the multichannel i2s/lj transmitter
package atx_pkg;
    typedef struct packed {
        logic [1:0] serial_format_select;
        logic [1:0] sample_word_length;
        logic [4:0] slot_offset;
        logic late_latch;
        logic master_en;
        logic bit_clock_invert;
        logic tristate_en;
        logic bus_hold_en;
        logic second_lane_en;
        logic daisy_en;
        logic auto_clk_en;
    } atx_cfg_s;
    typedef struct packed {
        logic clk_err;
        logic phase_err;
        logic [3:0] ratio_idx;
        logic [15:0] frame_cycles;
    } atx_status_s;
    typedef enum logic {LD_IDLE, LD_RUN} atx_load_e;
endpackage

/* File: atx_bus_model.sv */
// far-end audio bus master model: makes bit clock and frame sync, captures data
`timescale 1ns/10ps
`default_nettype none
module atx_bus_model #(
    parameter int HALF = 10,
    parameter int BITS = 64
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic run,
    input wire logic left_high,
    input wire logic sdout,
    input wire logic sdout_oe_n,
    output logic bit_clk,
    output logic frame_sync,
    output logic busy,
    output logic [63:0] left_bits,
    output logic [63:0] right_bits,
    output logic [7:0] left_drv,
    output logic [7:0] right_drv
);
    logic [7:0] div;
    logic [7:0] cnt;
    logic [7:0] drv;
    logic [63:0] shift_in;
    logic last_sd;
    logic sd_line;
    // released line has no pull: show the inverse so a stale level never matches
    assign sd_line = sdout_oe_n ? ~last_sd : sdout;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div <= 8'h00;
            cnt <= 8'h00;
            drv <= 8'h00;
            bit_clk <= 1'b1;
            frame_sync <= 1'b0;
            busy <= 1'b0;
            last_sd <= 1'b0;
        end else begin
            div <= (div == 8'(HALF - 1)) ? 8'h00 : div + 8'h01;
            if (div == 8'(HALF - 1)) begin
                if (!bit_clk) begin
                    bit_clk <= 1'b1;
                    shift_in <= {shift_in[62:0], sd_line};
                    drv <= drv + {7'h00, ~sdout_oe_n};
                    last_sd <= sd_line;
                end else if (!busy) begin
                    busy <= run;
                end else if (cnt == 8'(2 * BITS) && !run) begin
                    // clock stands still high between bursts
                    busy <= 1'b0;
                    cnt <= 8'h00;
                    right_bits <= shift_in;
                    right_drv <= drv;
                end else begin
                    bit_clk <= 1'b0;
                    if (cnt == 8'(BITS)) begin
                        left_bits <= shift_in;
                        left_drv <= drv;
                        drv <= 8'h00;
                        frame_sync <= ~left_high;
                        cnt <= cnt + 8'h01;
                    end else if (cnt == 8'h00 || cnt == 8'(2 * BITS)) begin
                        right_bits <= shift_in;
                        right_drv <= drv;
                        drv <= 8'h00;
                        frame_sync <= left_high;
                        cnt <= 8'h01;
                    end else begin
                        cnt <= cnt + 8'h01;
                    end
                end
            end
        end
    end
endmodule
`default_nettype wire

/* File: test_atx_tx.sv */
// self-checking bench for the transmitter in bus slave mode, then in bus master mode
`timescale 1ns/10ps
`default_nettype none
`include "atx_params.svh"
module test_atx_tx;
    import atx_pkg::*;
    localparam int HALF = 10;
    localparam int FRAME = 4 * 64 * HALF;
    localparam logic [31:0] WA = 32'hc3a5_9617;
    localparam logic [31:0] WB = 32'h5e0f_b2d1;
    localparam int DIV = 6;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    atx_cfg_s cfg = '0;
    logic [3:0][5:0] ch_slot = '0;
    logic smp_valid = 1'b0;
    logic [31:0] smp_data = 32'h0;
    logic run = 1'b0;
    logic left_high = 1'b0;
    logic [3:0] ch_en = 4'h3;
    logic [10:0] master_half_bits = 11'h040;
    logic frame_resync = 1'b0;
    logic general_input_pin = 1'b0;
    logic smp_ready, bit_clk, frame_sync, busy, sdout, sdout_oe_n;
    logic bclk_out, bclk_oe_n, fs_out, fs_oe_n, sdout_keep;
    atx_status_s status;
    logic [63:0] left_bits, right_bits;
    logic [7:0] left_drv, right_drv;
    int n_fail = 0;
    int n_checks = 0;
    int n_words;
    always #2 clk = ~clk;
    atx_tx #(.BCLK_HALF_DIV(DIV), .FIFO_DEPTH(16)) atx_tx_i (
        .clk(clk), .rst_n(rst_n), .cfg(cfg), .ch_en(ch_en), .ch_slot(ch_slot), .master_half_bits(master_half_bits),
        .frame_resync(frame_resync), .smp_valid(smp_valid), .smp_ready(smp_ready), .smp_data(smp_data),
        .bit_clk_pin_in(bit_clk), .bit_clk_pin_out(bclk_out), .bit_clk_pin_oe_n(bclk_oe_n),
        .frame_sync_pin_in(frame_sync), .frame_sync_pin_out(fs_out), .frame_sync_pin_oe_n(fs_oe_n),
        .sdout(sdout), .sdout_oe_n(sdout_oe_n), .sdout_keep(sdout_keep), .general_pin_one_out(),
        .general_pin_one_oe_n(), .general_input_pin(general_input_pin), .clock_detect_status(status));
    atx_bus_model #(.HALF(HALF), .BITS(64)) atx_bus_model_i (
        .clk(clk), .rst_n(rst_n), .run(run), .left_high(left_high), .sdout(sdout), .sdout_oe_n(sdout_oe_n),
        .bit_clk(bit_clk), .frame_sync(frame_sync), .busy(busy), .left_bits(left_bits),
        .right_bits(right_bits), .left_drv(left_drv), .right_drv(right_drv));
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // pushes word pairs until the fifo refuses; pairs keep channel order aligned
    task automatic fill(output int n);
        n = 0;
        @(posedge clk);
        smp_valid <= 1'b1;
        smp_data <= WA;
        for (int k = 0; k < 40; k++) begin
            @(negedge clk);
            if (smp_ready !== 1'b1) break;
            @(posedge clk);
            n++;
            smp_data <= n[0] ? WB : WA;
        end
        @(posedge clk);
        smp_valid <= 1'b0;
    endtask
    task automatic run_case(input logic [1:0] fmt, input logic [1:0] wlen, input logic [4:0] off,
                            input logic [5:0] slot1);
        fill(n_words);
        @(posedge clk);
        cfg.serial_format_select <= fmt;
        cfg.sample_word_length <= wlen;
        cfg.slot_offset <= off;
        ch_slot[1] <= slot1;
        left_high <= (fmt == `ATX_FMT_LJ);
        run <= 1'b1;
        repeat (3 * FRAME) @(posedge clk);
        run <= 1'b0;
        for (int k = 0; k < 2 * FRAME && busy === 1'b1; k++) @(posedge clk);
    endtask
    task automatic test_lj();
        run_case(`ATX_FMT_LJ, 2'h3, 5'h00, 6'h20);
        check("fifo words", 32'd16, 32'(n_words));
        check("lj left word", WA, left_bits[63:32]);
        check("lj right word", WB, right_bits[63:32]);
        check("lj left driven bits", 32'd32, {24'h0, left_drv});
        check("lj right driven bits", 32'd32, {24'h0, right_drv});
        check("ratio index", 32'h7, {28'h0, status.ratio_idx});
        check("frame clocks", 32'(FRAME), {16'h0, status.frame_cycles});
        check("phase error", 32'h0, {31'h0, status.phase_err});
        $display("test lj done");
    endtask
    task automatic test_i2s();
        run_case(`ATX_FMT_I2S, 2'h3, 5'h00, 6'h20);
        check("i2s left word", WA, left_bits[62:31]);
        check("i2s right word", WB, right_bits[62:31]);
        $display("test i2s done");
    endtask
    task automatic test_offset();
        run_case(`ATX_FMT_LJ, 2'h0, 5'h05, 6'h01);
        check("left slots 0 and 1", {WA[31:16], WB[31:16]}, left_bits[58:27]);
        check("left driven bits", 32'd32, {24'h0, left_drv});
        check("right driven bits", 32'd0, {24'h0, right_drv});
        $display("test offset done");
    endtask
    // master mode: own clocks, daisy forward, holder, then a ratio the detector must refuse
    task automatic test_master();
        int t1;
        @(posedge clk);
        cfg.master_en <= 1'b1;
        cfg.serial_format_select <= `ATX_FMT_LJ;
        cfg.slot_offset <= 5'h01;
        cfg.daisy_en <= 1'b1;
        ch_en <= 4'h0;
        general_input_pin <= 1'b1;
        master_half_bits <= 11'h010;
        frame_resync <= 1'b1;
        @(posedge clk);
        frame_resync <= 1'b0;
        repeat (10) @(negedge clk);
        check("resync starts left phase", 32'h1, {31'h0, fs_out});
        check("master pin drive", 32'h0, {30'h0, bclk_oe_n, fs_oe_n});
        check("daisy forward", 32'h2, {30'h0, sdout, sdout_oe_n});
        for (int k = 0; k < 1000 && fs_out !== 1'b0; k++) @(negedge clk);
        for (int k = 0; k < 1000 && fs_out !== 1'b1; k++) @(negedge clk);
        check("bit clock low at frame-sync edge", 32'h0, {31'h0, bclk_out});
        for (t1 = 0; t1 < 1000 && fs_out !== 1'b0; t1++) @(negedge clk);
        check("master phase clocks", 32'(2 * DIV * 16), 32'(t1));
        @(posedge clk);
        cfg.daisy_en <= 1'b0;
        cfg.bus_hold_en <= 1'b1;
        repeat (40) @(negedge clk);
        check("bus holder", 32'h3, {30'h0, sdout_keep, sdout_oe_n});
        @(posedge clk);
        cfg.auto_clk_en <= 1'b1;
        ch_en <= 4'h1;
        master_half_bits <= 11'h014;
        repeat (2000) @(negedge clk);
        check("unlisted ratio flagged", 32'h1, {31'h0, status.clk_err});
        $display("test master done");
    endtask
    initial begin
        cfg.tristate_en <= 1'b1;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        repeat (5) @(posedge clk);
        test_lj();
        test_i2s();
        test_offset();
        test_master();
        finish_test();
    end
    initial begin
        repeat (60000) @(posedge clk);
        n_fail++;
        $display("watchdog expired");
        finish_test();
    end
endmodule
`default_nettype wire
